// ### rtl/fbw_pkg.sv
// Shared constants for the fault resilient boot watchdog
package fbw_pkg;
	// Clock rate
	localparam int CLK_MHZ       = 250;
	localparam int CLK_HZ        = CLK_MHZ * 1000000;
	// Timeouts, in seconds except WD_TMO_MIN in minutes
	localparam int BOOT_TMO_S    = 5;
	localparam int WD_TMO_MIN    = 6;
	localparam int WD_TMO_S      = WD_TMO_MIN * 60;
	// System reset pulse, least width in ns, rounded up to cycles
	localparam int RST_PULSE_NS  = 1000;
	localparam int RST_CYC       = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_W         = $clog2(RST_CYC + 1);
	// Speaker tone and half period in cycles
	localparam int TONE_HZ       = 1000;
	localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
	// Periodic clock resync interval in seconds
	localparam int RESYNC_S      = 3600;
	// Counter widths
	localparam int BOOT_W        = 8;
	localparam int WD_W          = 16;
	localparam int TIME_W        = 32;
	localparam logic [BOOT_W-1:0] BOOT_TICKS = BOOT_W'(BOOT_TMO_S);
	localparam logic [WD_W-1:0]   WD_DEF     = WD_W'(WD_TMO_S);
endpackage

// ### rtl/fbw_sync2.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module fbw_sync2 #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// Level in and out
	input  wire logic pin_i,
	output logic      sync_o
);
	logic meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= RST_VAL;
			sync_o <= RST_VAL;
		end else if (clk_en) begin
			meta_r <= pin_i;
			sync_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ### rtl/fbw_cdown.sv
// Loadable seconds countdown with one expiry pulse per arming
`timescale 1ns/1ps
`default_nettype none
module fbw_cdown #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic         clk_en,
	// Control
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         stop,
	// State
	output logic [W-1:0]      count,
	output logic              running,
	output logic              expired
);
	generate
		if (W < 2) begin : g_bad
			$error("fbw_cdown: W must be at least 2");
		end
	endgenerate

	wire last_tick = running & tick & (count == W'(1));

	// Load wins over stop; expiry clears running so it fires once
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			count   <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (clk_en) begin
			expired <= last_tick & ~load & ~stop;
			if (load) begin
				count   <= load_val;
				running <= (load_val != '0);
			end else if (stop) begin
				running <= 1'b0;
			end else if (running & tick) begin
				count   <= count - W'(1);
				running <= ~last_tick;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/fbw_watchdog.sv
// Fault resilient boot supervision: boot timer, watchdog, rotation, timestamp
`timescale 1ns/1ps
`default_nettype none
module fbw_watchdog #(
	parameter int N_CPU      = 2,
	parameter int SEC_CYCLES = fbw_pkg::CLK_HZ,
	parameter int TONE_HALF  = fbw_pkg::TONE_HALF_CYC,
	parameter int RESYNC_SEC = fbw_pkg::RESYNC_S,
	localparam int CW        = (N_CPU < 2) ? 1 : $clog2(N_CPU)
) (
	// Clock, reset, enable
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	input  wire logic                        clk_en,
	// Board pins
	input  wire logic                        hard_reset_n,
	input  wire logic                        boot_timer_halt_n,
	// Host watchdog commands
	input  wire logic                        wd_arm_i,
	input  wire logic                        wd_disarm_i,
	input  wire logic [fbw_pkg::WD_W-1:0]    wd_timeout_s_i,
	// Host processor disable request
	input  wire logic                        dis_req_i,
	input  wire logic [CW-1:0]               dis_cpu_i,
	// Host timestamp commands
	input  wire logic                        time_get_i,
	input  wire logic                        time_set_i,
	input  wire logic [fbw_pkg::TIME_W-1:0]  time_set_val_i,
	// Real-time clock reader
	input  wire logic                        rtc_valid_i,
	input  wire logic [fbw_pkg::TIME_W-1:0]  rtc_val_i,
	output logic                             rtc_req_o,
	// Timestamp answer
	output logic                             time_ack_o,
	output logic [fbw_pkg::TIME_W-1:0]       time_val_o,
	// System control
	output logic                             sys_reset_o,
	output logic                             halt_o,
	output logic                             speaker_o,
	output logic [CW-1:0]                    boot_cpu_o,
	output logic [N_CPU-1:0]                 cpu_disabled_o,
	// Timer state
	output logic                             boot_run_o,
	output logic                             wd_run_o
);
	localparam int SCW = $clog2(SEC_CYCLES);
	localparam int TCW = $clog2(TONE_HALF + 1);
	localparam int RCW = $clog2(RESYNC_SEC + 1);

	generate
		if (N_CPU < 2 || SEC_CYCLES < 4 || TONE_HALF < 1 || RESYNC_SEC < 1) begin : g_bad
			$error("fbw_watchdog: parameter out of range");
		end
	endgenerate

	// Registers and next-state wires
	logic                        hr_d_r;
	logic                        own_rst_r;
	logic                        beep_r;
	logic [fbw_pkg::RST_W-1:0]   rst_cnt_r;
	logic [SCW-1:0]              sec_cnt_r;
	logic [TCW-1:0]              tone_cnt_r;
	logic [RCW-1:0]              rs_cnt_r;
	logic                        start_pend_r;
	logic [fbw_pkg::TIME_W-1:0]  time_cnt_r;
	logic [fbw_pkg::TIME_W-1:0]  time_nxt;
	logic [fbw_pkg::RST_W-1:0]   rst_cnt_nxt;
	logic [N_CPU-1:0]            dis_nxt;
	logic [CW-1:0]               boot_nxt;
	logic                        beep_nxt;
	logic                        halt_nxt;
	logic                        launch;
	// Synchronised pins and timer wires
	logic                        hr_s;
	logic                        hl_s;
	logic [fbw_pkg::BOOT_W-1:0]  boot_cnt;
	logic [fbw_pkg::WD_W-1:0]    wd_cnt;
	logic                        boot_exp;
	logic                        wd_exp;

	// Pin synchronisers
	fbw_sync2 #(.RST_VAL(1'b0)) u_sync_hr (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_i   (hard_reset_n),
		.sync_o  (hr_s)
	);
	fbw_sync2 #(.RST_VAL(1'b0)) u_sync_hl (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_i   (boot_timer_halt_n),
		.sync_o  (hl_s)
	);

	// Reset edges and one-second tick
	wire hr_rise     = hr_s & ~hr_d_r;
	wire hr_fall     = ~hr_s & hr_d_r;
	wire ext_restart = hr_fall & ~own_rst_r;
	wire sec_tick    = (sec_cnt_r == SCW'(SEC_CYCLES - 1));
	wire beep_phase  = (sec_cnt_r < SCW'(SEC_CYCLES / 2));
	wire tone_wrap   = (tone_cnt_r == TCW'(TONE_HALF - 1));
	wire rs_wrap     = sec_tick & (rs_cnt_r == RCW'(RESYNC_SEC - 1));

	// Boot timer loads on reset release, stops on halt deassert
	fbw_cdown #(.W(fbw_pkg::BOOT_W)) u_boot_tmr (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.tick     (sec_tick),
		.load     (hr_rise),
		.load_val (fbw_pkg::BOOT_TICKS),
		.stop     (hl_s | hr_fall),
		.count    (boot_cnt),
		.running  (boot_run_o),
		.expired  (boot_exp)
	);

	// Startup watchdog from host setting
	fbw_cdown #(.W(fbw_pkg::WD_W)) u_wd_tmr (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.tick     (sec_tick),
		.load     (wd_arm_i),
		.load_val (wd_timeout_s_i),
		.stop     (wd_disarm_i | hr_fall),
		.count    (wd_cnt),
		.running  (wd_run_o),
		.expired  (wd_exp)
	);

	// One-hot views of the boot and requested processors
	logic [N_CPU-1:0] boot_oh;
	logic [N_CPU-1:0] req_oh;
	genvar g;
	generate
		for (g = 0; g < N_CPU; g++) begin : g_oh
			assign boot_oh[g] = (boot_cpu_o == CW'(g));
			assign req_oh[g]  = (dis_cpu_i == CW'(g));
		end
	endgenerate

	// Next usable processor after cur; top bit flags that one exists
	function automatic logic [CW:0] pick_next(input logic [CW-1:0] cur,
		input logic [N_CPU-1:0] dis);
		logic [CW:0] res;
		int          k;
		int          idx;
		res = '0;
		for (k = N_CPU - 1; k >= 1; k--) begin
			idx = (int'(cur) + k) % N_CPU;
			if (!dis[idx]) begin
				res = {1'b1, CW'(idx)};
			end
		end
		return res;
	endfunction

	// Event priority: outside reset, boot expiry, disable, watchdog
	wire [N_CPU-1:0] mask_a      = cpu_disabled_o | boot_oh;
	wire [N_CPU-1:0] mask_d      = cpu_disabled_o | req_oh;
	wire [CW:0]      pick_a      = pick_next(boot_cpu_o, mask_a);
	wire [CW:0]      pick_d      = pick_next(boot_cpu_o, mask_d);
	wire             dis_is_boot = (dis_cpu_i == boot_cpu_o);
	wire             ev_boot     = boot_exp & ~ext_restart;
	wire             ev_dis      = dis_req_i & ~boot_exp & ~ext_restart;
	wire             ev_wd       = wd_exp & ~boot_exp & ~dis_req_i & ~ext_restart;

	// Rotation and fault decisions
	always_comb begin
		dis_nxt  = cpu_disabled_o;
		boot_nxt = boot_cpu_o;
		beep_nxt = beep_r;
		halt_nxt = halt_o;
		launch   = 1'b0;
		if (ext_restart) begin
			dis_nxt  = '0;
			boot_nxt = '0;
			beep_nxt = 1'b0;
			halt_nxt = 1'b0;
		end else if (ev_boot) begin
			dis_nxt = mask_a;
			if (pick_a[CW]) begin
				boot_nxt = pick_a[CW-1:0];
				launch   = 1'b1;
			end else begin
				beep_nxt = 1'b1;
				halt_nxt = 1'b1;
			end
		end else if (ev_dis) begin
			dis_nxt = mask_d;
			if (!dis_is_boot) begin
				launch = 1'b1;
			end else if (pick_d[CW]) begin
				boot_nxt = pick_d[CW-1:0];
				launch   = 1'b1;
			end else begin
				beep_nxt = 1'b1;
				halt_nxt = 1'b1;
			end
		end else if (ev_wd) begin
			launch = 1'b1;
		end
	end

	// Reset pulse length
	assign rst_cnt_nxt = launch ? fbw_pkg::RST_W'(fbw_pkg::RST_CYC) :
		(rst_cnt_r != '0) ? rst_cnt_r - fbw_pkg::RST_W'(1) : rst_cnt_r;

	// Timestamp: host set, then clock load, then the seconds step
	always_comb begin
		time_nxt = time_cnt_r;
		if (time_set_i) begin
			time_nxt = time_set_val_i;
		end else if (rtc_valid_i) begin
			time_nxt = rtc_val_i;
		end else if (sec_tick) begin
			time_nxt = time_cnt_r + fbw_pkg::TIME_W'(1);
		end
	end

	// Supervision state
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hr_d_r         <= 1'b0;
			own_rst_r      <= 1'b0;
			cpu_disabled_o <= '0;
			boot_cpu_o     <= '0;
			beep_r         <= 1'b0;
			halt_o         <= 1'b0;
			rst_cnt_r      <= '0;
			sys_reset_o    <= 1'b0;
		end else if (clk_en) begin
			hr_d_r         <= hr_s;
			own_rst_r      <= launch | (own_rst_r & ~(hr_rise & ~sys_reset_o)); // Pin blips mid-pulse
			cpu_disabled_o <= dis_nxt;
			boot_cpu_o     <= boot_nxt;
			beep_r         <= beep_nxt;
			halt_o         <= halt_nxt;
			rst_cnt_r      <= rst_cnt_nxt;
			sys_reset_o    <= (rst_cnt_nxt != '0);
		end
	end

	// Seconds prescaler and beep tone
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sec_cnt_r  <= '0;
			tone_cnt_r <= '0;
			speaker_o  <= 1'b0;
		end else if (clk_en) begin
			sec_cnt_r  <= sec_tick ? '0 : sec_cnt_r + SCW'(1);
			tone_cnt_r <= tone_wrap ? '0 : tone_cnt_r + TCW'(1);
			if (!(beep_r & beep_phase)) begin
				speaker_o <= 1'b0;
			end else if (tone_wrap) begin
				speaker_o <= ~speaker_o;
			end
		end
	end

	// Timestamp and clock resync requests
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			time_cnt_r   <= '0;
			time_val_o   <= '0;
			time_ack_o   <= 1'b0;
			rs_cnt_r     <= '0;
			start_pend_r <= 1'b1;
			rtc_req_o    <= 1'b0;
		end else if (clk_en) begin
			time_cnt_r   <= time_nxt;
			time_ack_o   <= time_get_i;
			if (time_get_i) begin
				time_val_o <= time_cnt_r;
			end
			if (sec_tick) begin
				rs_cnt_r <= rs_wrap ? '0 : rs_cnt_r + RCW'(1);
			end
			start_pend_r <= 1'b0;
			rtc_req_o    <= start_pend_r | rs_wrap;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	chk_boot_start_load: assert property (clk_en && hr_rise |=> boot_run_o)
		else $error("boot timer not started on reset release");
	chk_boot_halt_stop: assert property (clk_en && hl_s && !hr_rise |=> !boot_run_o)
		else $error("boot timer still running after halt");
	chk_boot_exp_reset: assert property (clk_en && ev_boot && pick_a[CW]
		|=> sys_reset_o && cpu_disabled_o == $past(mask_a))
		else $error("boot expiry did not reset and disable");
	chk_rotate_boot_cpu: assert property (clk_en && ev_boot && pick_a[CW]
		|=> boot_cpu_o != $past(boot_cpu_o))
		else $error("boot processor not rotated");
	chk_beep_no_cpu: assert property (clk_en && ev_boot && !pick_a[CW]
		|=> beep_r && halt_o ##1 beep_r)
		else $error("no beep with all processors failed");
	chk_rotation_restart: assert property (clk_en && ext_restart
		|=> boot_cpu_o == '0 && cpu_disabled_o == '0 && !beep_r)
		else $error("rotation not restarted");
	chk_wd_arm_load: assert property (clk_en && wd_arm_i
		|=> wd_cnt == $past(wd_timeout_s_i))
		else $error("watchdog not loaded from setting");
	chk_wd_reset: assert property (clk_en && ev_wd |=> sys_reset_o ##1 sys_reset_o)
		else $error("watchdog expiry gave no reset");
	chk_ap_disable: assert property (clk_en && ev_dis && !dis_is_boot
		|=> sys_reset_o && cpu_disabled_o[$past(dis_cpu_i)])
		else $error("application processor disable failed");
	chk_bsp_halt: assert property (clk_en && ev_dis && dis_is_boot && !pick_d[CW]
		|=> halt_o && beep_r && !sys_reset_o)
		else $error("lone boot processor disable not halted");
	chk_bsp_transfer: assert property (clk_en && ev_dis && dis_is_boot && pick_d[CW]
		|=> sys_reset_o && boot_cpu_o == $past(pick_d[CW-1:0]))
		else $error("boot ownership not transferred");
	chk_time_step: assert property (clk_en && sec_tick && !time_set_i && !rtc_valid_i
		|=> time_cnt_r == $past(time_cnt_r) + 32'h0000_0001)
		else $error("timestamp did not step");
	chk_time_get: assert property (clk_en && time_get_i
		|=> time_ack_o && time_val_o == $past(time_cnt_r))
		else $error("get time answer wrong");
	chk_rtc_load: assert property (clk_en && rtc_valid_i && !time_set_i
		|=> time_cnt_r == $past(rtc_val_i))
		else $error("clock value not loaded");
	chk_exp_once: assert property (boot_exp |-> !boot_run_o ##1 !boot_exp)
		else $error("boot expiry repeated");
endmodule
`default_nettype wire

// ### testbench/fbw_host_model.sv
// Boot firmware and clock chip stand-in facing the boot watchdog
`timescale 1ns/1ps
`default_nettype none
module fbw_host_model #(
	parameter logic [31:0] RTC_VAL = 32'h5a5a_0000
) (
	// Clock and reset
	input  wire logic   clk_sys,
	input  wire logic   sys_rst,
	// Bench control
	input  wire logic   start_boot,
	// Device side
	input  wire logic   rtc_req,
	output logic        wd_arm,
	output logic        boot_timer_halt_n,
	output logic        rtc_valid,
	output logic [31:0] rtc_val
);
	logic [1:0] seq_r;
	logic [1:0] rtc_dly_r;

	// Boot progress and clock chip answer delay
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seq_r     <= 2'h0;
			rtc_dly_r <= 2'h0;
		end else begin
			seq_r     <= !start_boot ? 2'h0 : (seq_r == 2'h3 ? seq_r : seq_r + 2'h1);
			rtc_dly_r <= {rtc_dly_r[0], rtc_req};
		end
	end

	// Arm first, stop the boot timer two cycles later
	assign wd_arm            = (seq_r == 2'h1);
	assign boot_timer_halt_n = (seq_r == 2'h3);
	// Time word only valid with its strobe, inverted otherwise
	assign rtc_valid         = rtc_dly_r[1];
	assign rtc_val           = rtc_dly_r[1] ? RTC_VAL : ~RTC_VAL;
endmodule
`default_nettype wire

// ### testbench/fbw_watchdog_tb.sv
// Self-checking bench for the boot watchdog
`timescale 1ns/1ps
`default_nettype none
module fbw_watchdog_tb;
	localparam int          SEC   = 16;
	localparam logic [31:0] RTC_V = 32'h5a5a_0000;
	localparam logic [31:0] SET_V = 32'hc0de_0100;
	logic        clk_sys    = 1'b0;
	logic        sys_rst    = 1'b1;
	logic        clk_en     = 1'b1;
	logic        hr_ext_n   = 1'b1;
	logic        start_boot = 1'b0;
	logic        wd_disarm  = 1'b0;
	logic [15:0] wd_tmo     = 16'h0003;
	logic        dis_req    = 1'b0;
	logic        dis_cpu    = 1'b0;
	logic        t_get      = 1'b0;
	logic        t_set      = 1'b0;
	logic [31:0] t_val      = 32'h0;
	logic        hard_reset_n;
	logic        wd_arm;
	logic        halt_n;
	logic        rtc_valid;
	logic [31:0] rtc_val;
	logic        rtc_req;
	logic        time_ack;
	logic [31:0] time_val;
	logic        sys_reset;
	logic        halt;
	logic        speaker;
	logic        boot_cpu;
	logic [1:0]  cpu_dis;
	logic        boot_run;
	logic        wd_run;
	int          failures   = 0;
	int          n_compared = 0;

	// Clock, and own system reset looped back onto the board reset pin
	always #2 clk_sys = ~clk_sys;
	assign hard_reset_n = hr_ext_n & ~sys_reset;

	fbw_watchdog #(.N_CPU(2), .SEC_CYCLES(SEC), .TONE_HALF(2), .RESYNC_SEC(4)) fbw_watchdog_inst (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
		.hard_reset_n(hard_reset_n), .boot_timer_halt_n(halt_n),
		.wd_arm_i(wd_arm), .wd_disarm_i(wd_disarm), .wd_timeout_s_i(wd_tmo),
		.dis_req_i(dis_req), .dis_cpu_i(dis_cpu),
		.time_get_i(t_get), .time_set_i(t_set), .time_set_val_i(t_val),
		.rtc_valid_i(rtc_valid), .rtc_val_i(rtc_val), .rtc_req_o(rtc_req),
		.time_ack_o(time_ack), .time_val_o(time_val),
		.sys_reset_o(sys_reset), .halt_o(halt), .speaker_o(speaker),
		.boot_cpu_o(boot_cpu), .cpu_disabled_o(cpu_dis),
		.boot_run_o(boot_run), .wd_run_o(wd_run)
	);

	fbw_host_model #(.RTC_VAL(RTC_V)) fbw_host_model_inst (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .start_boot(start_boot),
		.rtc_req(rtc_req), .wd_arm(wd_arm), .boot_timer_halt_n(halt_n),
		.rtc_valid(rtc_valid), .rtc_val(rtc_val)
	);

	// Comparison, verdict and timing helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return sys_reset;
			1: return boot_run;
			2: return rtc_req;
			3: return halt;
			default: return speaker;
		endcase
	endfunction

	task automatic wait_lvl(input int k, input logic v, input int lim);
		for (int i = 0; i < lim; i++) begin
			if (pick(k) === v)
				return;
			step(1);
		end
		failures++;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, pick(k), v);
		stop_test();
	endtask

	task automatic stay_low(input int k, input int n, output logic bad);
		bad = 1'b0;
		repeat (n) begin
			bad = bad | pick(k);
			step(1);
		end
	endtask

	task automatic get(output logic [31:0] v);
		t_get = 1'b1;
		step(1);
		t_get = 1'b0;
		check(32'(time_ack), 32'h1);
		v = time_val;
	endtask

	task automatic dis(input logic cpu);
		dis_cpu = cpu;
		dis_req = 1'b1;
		step(1);
		dis_req = 1'b0;
	endtask

	task automatic ext_reset;
		// Let a just-released pin be seen high before pulling it again
		step(6);
		hr_ext_n = 1'b0;
		step(5);
		check(32'(cpu_dis), 32'h0);
		check(32'(boot_cpu), 32'h0);
		check(32'(halt), 32'h0);
		hr_ext_n = 1'b1;
	endtask

	// Scenarios
	task automatic sc_boot_ok;
		logic bad;
		wait_lvl(1, 1'b1, 10);
		wd_tmo = fbw_pkg::WD_DEF;
		start_boot = 1'b1;
		wait_lvl(1, 1'b0, 12);
		check(32'(wd_run), 32'h1);
		stay_low(0, 8 * SEC, bad);
		check(32'(bad), 32'h0);
		wd_disarm = 1'b1;
		step(1);
		wd_disarm = 1'b0;
		check(32'(wd_run), 32'h0);
	endtask

	task automatic sc_time;
		logic [31:0] t0;
		logic [31:0] t1;
		wait_lvl(2, 1'b1, 80);
		step(4);
		get(t0);
		check(32'(t0 === RTC_V || t0 === RTC_V + 32'h1), 32'h1);
		t_val = SET_V;
		t_set = 1'b1;
		step(1);
		t_set = 1'b0;
		get(t0);
		check(32'(t0 === SET_V || t0 === SET_V + 32'h1), 32'h1);
		step(31);
		get(t1);
		check(t1 - t0, 32'h2);
		// Frozen enable: no second may pass
		clk_en = 1'b0;
		step(40);
		clk_en = 1'b1;
		get(t1);
		check(t1 - t0, 32'h2);
	endtask

	task automatic sc_disable;
		int w;
		dis(1'b1);
		check(32'(cpu_dis), 32'h2);
		check(32'(sys_reset), 32'h1);
		w = 0;
		while (sys_reset === 1'b1 && w < 300) begin
			w++;
			step(1);
		end
		check(32'(w), 32'd250);
		dis(1'b0);
		check(32'(halt), 32'h1);
		check(32'(sys_reset), 32'h0);
		wait_lvl(4, 1'b1, 2 * SEC);
		ext_reset();
		dis(1'b0);
		check(32'(boot_cpu), 32'h1);
		check(32'(cpu_dis), 32'h1);
		check(32'(sys_reset), 32'h1);
		wait_lvl(0, 1'b0, 260);
		check(32'(boot_cpu), 32'h1);
		check(32'(cpu_dis), 32'h1);
	endtask

	task automatic sc_rotate;
		start_boot = 1'b0;
		ext_reset();
		wait_lvl(0, 1'b1, 6 * SEC);
		check(32'(cpu_dis), 32'h1);
		check(32'(boot_cpu), 32'h1);
		wait_lvl(0, 1'b0, 260);
		wait_lvl(3, 1'b1, 7 * SEC);
		check(32'(cpu_dis), 32'h3);
		check(32'(sys_reset), 32'h0);
		wait_lvl(4, 1'b1, 2 * SEC);
		ext_reset();
	endtask

	task automatic sc_wd;
		logic bad;
		wd_tmo = 16'h0003;
		start_boot = 1'b1;
		stay_low(0, 2 * SEC, bad);
		check(32'(bad), 32'h0);
		wait_lvl(0, 1'b1, 24);
		check(32'(cpu_dis), 32'h0);
		wait_lvl(0, 1'b0, 260);
	endtask

	// Main sequence
	initial begin
		step(10);
		sys_rst = 1'b0;
		sc_boot_ok();
		sc_time();
		sc_disable();
		sc_rotate();
		sc_wd();
		stop_test();
	end
endmodule
`default_nettype wire
